/* include/osc_pkg.sv */
// Purpose: shared constants and types of the oscillator controller
// Assumes: 32-bit apb, byte addresses, one word per register
// Notes: indices of oscillators and status bits fixed below
package osc_pkg;
  localparam int OSC_N = 7;
  localparam int ST_N = 10;
  // oscillator indices
  localparam int OSC_FAST_XTAL = 0;
  localparam int OSC_SLOW_XTAL = 1;
  localparam int OSC_SLOW_INT = 2;
  localparam int OSC_ULP = 3;
  localparam int OSC_8M = 4;
  localparam int OSC_FLL = 5;
  localparam int OSC_PLL = 6;
  // register offsets
  localparam logic [7:0] OFF_INTENCLR = 8'h00;
  localparam logic [7:0] OFF_INTENSET = 8'h04;
  localparam logic [7:0] OFF_INTFLAG = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_OSC_BASE = 8'h10;
  localparam logic [7:0] OFF_BOD_IO = 8'h2C;
  localparam logic [7:0] OFF_BOD_CORE = 8'h30;
  localparam logic [7:0] OFF_VREF = 8'h34;
  // control word fields
  localparam int EN_BIT = 1;
  localparam int RUNSTDBY_BIT = 6;
  localparam int ONDEM_BIT = 7;
  localparam int CAL_LSB = 16;
  localparam int CAL_W = 16;
  localparam logic [31:0] CTRL_MASK = 32'hFFFF00C2;
  localparam logic [31:0] CTRL_RST = 32'h00000080;
  localparam logic [31:0] BOD_MASK = 32'hFFFF0002;
  localparam logic [31:0] BOD_RST = 32'h00000000;
  localparam logic [15:0] VREF_RST = 16'h0000;
  // status and interrupt bit positions
  localparam int ST_FAST_RDY = 0;
  localparam int ST_SLOWX_RDY = 1;
  localparam int ST_SLOWI_RDY = 2;
  localparam int ST_8M_RDY = 3;
  localparam int ST_FLL_RDY = 4;
  localparam int ST_FLL_OOB = 5;
  localparam int ST_FLL_FINE = 6;
  localparam int ST_PLL_LOCK = 7;
  localparam int ST_BOD_IO = 8;
  localparam int ST_BOD_CORE = 9;
  localparam logic [ST_N-1:0] INTEN_RST = 10'h000;
  localparam logic [ST_N-1:0] WAKE_MASK = 10'h300;
  localparam int SYNC_STAGES = 3;
  // sleep level, one-hot
  typedef enum logic [2:0] {
    MODE_ACTIVE = 3'b001,
    MODE_IDLE = 3'b010,
    MODE_STANDBY = 3'b100
  } osc_mode_t;
endpackage : osc_pkg

/* include/osc_stat_if.sv */
// Purpose: carries raw and filtered status between controller and filter
// Assumes: one clock domain on the filtered side
// Notes: raw bits come from analog cells
`timescale 1ns/1ns
interface osc_stat_if;
  logic [osc_pkg::ST_N-1:0] raw;
  logic [osc_pkg::ST_N-1:0] clean;
  modport filt (input raw, output clean);
  modport ctrl (output raw, input clean);
endinterface : osc_stat_if

/* rtl/osc_ctrl_top.sv */
// Purpose: oscillator enable, sleep behaviour and interrupt control
// Assumes: zero-wait apb slave, sleep level and requests on pclk
// Notes: status inputs are filtered in osc_status_sync
`timescale 1ns/1ns
module osc_ctrl_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire osc_pkg::osc_mode_t sleep_mode,
  input wire logic [osc_pkg::OSC_N-1:0] clk_req,
  input wire logic [osc_pkg::ST_N-1:0] stat_raw,
  output logic [osc_pkg::OSC_N-1:0] osc_run,
  output logic [osc_pkg::OSC_N*osc_pkg::CAL_W-1:0] osc_cal,
  output logic [1:0] bod_en,
  output logic [2*osc_pkg::CAL_W-1:0] bod_cal,
  output logic [osc_pkg::CAL_W-1:0] vref_cal,
  output logic irq,
  output logic wake
);
  import osc_pkg::*;

  // address match on the word
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction : hit

  ////////////////////////////////////////////////////////////
  // status filter
  osc_stat_if st_if ();
  assign st_if.raw = stat_raw;

  osc_status_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .st(st_if)
  );

  ////////////////////////////////////////////////////////////
  // apb decode
  logic setup;
  logic wr;
  logic mapped;
  logic [31:0] rdata;
  logic [31:0] ctrl_q [OSC_N];
  logic [31:0] bod_q [2];
  logic [CAL_W-1:0] vref_q;
  logic [ST_N-1:0] inten_q;
  logic [ST_N-1:0] flag_q;
  logic [ST_N-1:0] flag_d;
  logic [ST_N-1:0] prev_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  assign setup = psel && !penable;
  assign wr = psel && penable && pready_q && pwrite;

  // read mux; unmapped words read zero and raise pslverr
  always_comb begin
    rdata = 32'h00000000;
    mapped = 1'b1;
    if (hit(paddr, OFF_INTENCLR) || hit(paddr, OFF_INTENSET)) begin
      rdata[ST_N-1:0] = inten_q;
    end else if (hit(paddr, OFF_INTFLAG)) begin
      rdata[ST_N-1:0] = flag_q;
    end else if (hit(paddr, OFF_STATUS)) begin
      rdata[ST_N-1:0] = st_if.clean;
    end else if (hit(paddr, OFF_BOD_IO)) begin
      rdata = bod_q[0];
    end else if (hit(paddr, OFF_BOD_CORE)) begin
      rdata = bod_q[1];
    end else if (hit(paddr, OFF_VREF)) begin
      rdata[CAL_LSB +: CAL_W] = vref_q;
    end else begin
      mapped = 1'b0;
    end
    for (int i = 0; i < OSC_N; i++) begin
      if (hit(paddr, OFF_OSC_BASE + 8'(4 * i))) begin
        rdata = ctrl_q[i];
        mapped = 1'b1;
      end
    end
  end

  // answer is registered in the setup cycle: access phase sees pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !mapped;
      if (setup && !pwrite) begin
        prdata_q <= rdata;
      end
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  ////////////////////////////////////////////////////////////
  // oscillator control words
  genvar g;
  generate
    for (g = 0; g < OSC_N; g++) begin : g_ctrl
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctrl_q[g] <= CTRL_RST;
        end else if (wr && hit(paddr, OFF_OSC_BASE + 8'(4 * g))) begin
          ctrl_q[g] <= pwdata & CTRL_MASK;
        end
      end
      assign osc_cal[g*CAL_W +: CAL_W] = ctrl_q[g][CAL_LSB +: CAL_W];
    end
  endgenerate

  // brown-out detectors and reference calibration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bod_q[0] <= BOD_RST;
      bod_q[1] <= BOD_RST;
      vref_q <= VREF_RST;
    end else if (wr) begin
      if (hit(paddr, OFF_BOD_IO)) begin
        bod_q[0] <= pwdata & BOD_MASK;
      end
      if (hit(paddr, OFF_BOD_CORE)) begin
        bod_q[1] <= pwdata & BOD_MASK;
      end
      if (hit(paddr, OFF_VREF)) begin
        vref_q <= pwdata[CAL_LSB +: CAL_W];
      end
    end
  end

  assign bod_en = {bod_q[1][EN_BIT], bod_q[0][EN_BIT]};
  assign bod_cal = {bod_q[1][CAL_LSB +: CAL_W], bod_q[0][CAL_LSB +: CAL_W]};
  assign vref_cal = vref_q;

  ////////////////////////////////////////////////////////////
  // run decision per oscillator and sleep level
  logic [OSC_N-1:0] run_q;
  generate
    for (g = 0; g < OSC_N; g++) begin : g_run
      logic en;
      logic want;
      assign en = ctrl_q[g][EN_BIT];
      // on-demand cleared means run regardless of requests
      assign want = !ctrl_q[g][ONDEM_BIT] || clk_req[g];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          run_q[g] <= (g == OSC_ULP);
        end else if (g == OSC_ULP) begin
          run_q[g] <= 1'b1;
        end else begin
          case (sleep_mode)
            MODE_ACTIVE: run_q[g] <= en;
            MODE_IDLE: run_q[g] <= en && want;
            MODE_STANDBY: run_q[g] <= en && ctrl_q[g][RUNSTDBY_BIT] && want;
            default: run_q[g] <= en;
          endcase
        end
      end
    end
  endgenerate
  assign osc_run = run_q;

  ////////////////////////////////////////////////////////////
  // interrupt enables, set and clear by writing ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inten_q <= INTEN_RST;
    end else if (wr && hit(paddr, OFF_INTENSET)) begin
      inten_q <= inten_q | pwdata[ST_N-1:0];
    end else if (wr && hit(paddr, OFF_INTENCLR)) begin
      inten_q <= inten_q & ~pwdata[ST_N-1:0];
    end
  end

  // sticky flags on rising status; a new edge beats a clear
  always_comb begin
    flag_d = flag_q;
    if (wr && hit(paddr, OFF_INTFLAG)) begin
      flag_d = flag_q & ~pwdata[ST_N-1:0];
    end
    flag_d = flag_d | (st_if.clean & ~prev_q);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= '0;
      flag_q <= '0;
    end else begin
      prev_q <= st_if.clean;
      flag_q <= flag_d;
    end
  end

  // request line and standby wake
  logic irq_q;
  logic wake_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      irq_q <= |(flag_q & inten_q);
      wake_q <= (sleep_mode == MODE_STANDBY) && |(flag_q & inten_q & WAKE_MASK);
    end
  end
  assign irq = irq_q;
  assign wake = wake_q;

  ////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_answer_timing: assert property (setup |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");
  a_cal_write: assert property (wr && hit(paddr, OFF_OSC_BASE) |=>
    osc_cal[CAL_W-1:0] == $past(pwdata[CAL_LSB +: CAL_W]))
    else $error("calibration not updated");
  a_disabled_stops: assert property (!ctrl_q[OSC_8M][EN_BIT] |=> !osc_run[OSC_8M])
    else $error("disabled oscillator running");
  a_idle_no_req: assert property (sleep_mode == MODE_IDLE && ctrl_q[OSC_FLL][ONDEM_BIT]
    && !clk_req[OSC_FLL] |=> !osc_run[OSC_FLL])
    else $error("idle oscillator ran without request");
  a_standby_stop: assert property (sleep_mode == MODE_STANDBY
    && !ctrl_q[OSC_PLL][RUNSTDBY_BIT] |=> !osc_run[OSC_PLL])
    else $error("standby oscillator not stopped");
  a_ulp_runs: assert property (osc_run[OSC_ULP])
    else $error("ultra low power oscillator stopped");
  a_set_only: assert property (wr && hit(paddr, OFF_INTENSET) |=>
    inten_q == ($past(inten_q) | $past(pwdata[ST_N-1:0])))
    else $error("enable set register misbehaved");
  a_clear_only: assert property (wr && hit(paddr, OFF_INTENCLR) |=>
    inten_q == ($past(inten_q) & ~$past(pwdata[ST_N-1:0])))
    else $error("enable clear register misbehaved");
  a_irq_gate: assert property ((flag_q & inten_q) != '0 |=> irq)
    else $error("enabled flag gave no request");
  a_irq_masked: assert property (flag_q[ST_FLL_FINE] && !inten_q[ST_FLL_FINE]
    && (flag_q & inten_q) == '0 |=> !irq)
    else $error("request without enable");
  a_flag_sticky: assert property (st_if.clean[ST_FLL_OOB] && !prev_q[ST_FLL_OOB]
    |=> flag_q[ST_FLL_OOB] [*2])
    else $error("flag not set on status edge");

  c_idle_request: cover property (sleep_mode == MODE_IDLE && clk_req[OSC_8M] ##1 osc_run[OSC_8M]);
  c_irq_raised: cover property (!irq ##1 irq);
  c_standby_wake: cover property (sleep_mode == MODE_STANDBY ##1 wake);
endmodule : osc_ctrl_top

/* rtl/osc_status_sync.sv */
// Purpose: three-stage synchroniser with agreement filter
// Assumes: status inputs are asynchronous to pclk
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ns
module osc_status_sync (
  input wire logic pclk,
  input wire logic presetn,
  osc_stat_if.filt st
);
  import osc_pkg::*;

  ////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < ST_N; g++) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic out_q;
      // first stage feeds only the second
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end else begin
          s1_q <= st.raw[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      // a glitch seen by one stage only is dropped
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          out_q <= 1'b0;
        end else if (s2_q == s3_q) begin
          out_q <= s3_q;
        end
      end
      assign st.clean[g] = out_q;
    end
  endgenerate
endmodule : osc_status_sync

/* verif/osc_ctrl_top_bench.sv */
// Purpose: self-checking bench of the oscillator controller
// Assumes: zero-wait apb slave, status filter settles within a few cycles
// Notes: random words come from an lfsr started at 32'hBA2B
`timescale 1ns/1ns
module osc_ctrl_top_bench;
  import osc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  osc_mode_t sleep_mode = MODE_ACTIVE;
  logic [OSC_N-1:0] clk_req = '0;
  logic [ST_N-1:0] stat_raw = '0;
  logic [OSC_N-1:0] osc_run;
  logic [OSC_N*CAL_W-1:0] osc_cal;
  logic [1:0] bod_en;
  logic [2*CAL_W-1:0] bod_cal;
  logic [CAL_W-1:0] vref_cal;
  logic irq;
  logic wake;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic [31:0] seed;
  logic [31:0] w;
  logic err;
  logic [31:0] ctrl_w [OSC_N];

  osc_ctrl_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_mode(sleep_mode), .clk_req(clk_req), .stat_raw(stat_raw), .osc_run(osc_run),
    .osc_cal(osc_cal), .bod_en(bod_en), .bod_cal(bod_cal), .vref_cal(vref_cal), .irq(irq), .wake(wake));

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard; the ceiling is far above the six hundred or so cycles used
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      error_cnt++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next pseudo-random word
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // expected run enables from the words written so far
  function automatic logic [OSC_N-1:0] exp_run(input osc_mode_t m, input logic [OSC_N-1:0] req);
    logic [OSC_N-1:0] r;
    for (int i = 0; i < OSC_N; i++) begin
      r[i] = ctrl_w[i][EN_BIT] & (!ctrl_w[i][ONDEM_BIT] | req[i]);
      if (m == MODE_ACTIVE) r[i] = ctrl_w[i][EN_BIT];
      if (m == MODE_STANDBY) r[i] = r[i] & ctrl_w[i][RUNSTDBY_BIT];
    end
    r[OSC_ULP] = 1'b1;
    return r;
  endfunction : exp_run

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic test_done();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////
  // main sequence: reset, random control words, interrupt gating, wake
  initial begin
    for (int i = 0; i < OSC_N; i++) ctrl_w[i] = CTRL_RST;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'(osc_run), 32'h00000008);
    apb(1'b0, OFF_OSC_BASE, 32'h0);
    chk(rd, 32'h00000080);
    seed = 32'hBA2B;
    // first pass is the corner: kept running in standby with no request
    for (int k = 0; k < 40; k++) begin
      int n;
      seed = lfsr(seed);
      n = (k == 0) ? OSC_8M : int'(seed[2:0]) % OSC_N;
      w = (k == 0) ? 32'h00000042 : seed & CTRL_MASK;
      apb(1'b1, OFF_OSC_BASE + 8'(4 * n), w);
      ctrl_w[n] = w;
      apb(1'b0, OFF_OSC_BASE + 8'(4 * n), 32'h0);
      chk(rd, w);
      chk(32'(osc_cal[n*CAL_W +: CAL_W]), 32'(w[31:16]));
      sleep_mode <= (k == 0 || seed[9]) ? MODE_STANDBY : (seed[8] ? MODE_IDLE : MODE_ACTIVE);
      clk_req <= (k == 0) ? '0 : seed[22:16];
      repeat (2) @(posedge pclk);
      chk(32'(osc_run), 32'(exp_run(sleep_mode, clk_req)));
    end
    apb(1'b1, OFF_BOD_CORE, 32'hABCD0002);
    apb(1'b1, OFF_VREF, 32'h5A5A0000);
    @(posedge pclk);
    chk(32'({bod_en, bod_cal[31:16]}), 32'h0002ABCD);
    chk(32'(vref_cal), 32'h00005A5A);
    // io detector: its half of the calibration and its enable bit
    apb(1'b1, OFF_BOD_IO, 32'h13570002);
    @(posedge pclk);
    chk(32'(bod_cal), 32'hABCD1357);
    chk(32'(bod_en), 32'h00000003);
    apb(1'b0, 8'hFC, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    sleep_mode <= MODE_ACTIVE;
    // flags 1 to 6: silent while disabled, irq once set, silent after clear
    for (int b = 1; b < 7; b++) begin
      stat_raw[b] <= 1'b1;
      repeat (10) @(posedge pclk);
      chk(32'(irq), 32'h0);
      apb(1'b0, OFF_STATUS, 32'h0);
      chk(rd, 32'h1 << b);
      apb(1'b1, OFF_INTENSET, 32'h1 << b);
      repeat (3) @(posedge pclk);
      chk(32'(irq), 32'h1);
      apb(1'b1, OFF_INTENSET, 32'h0);
      apb(1'b0, OFF_INTENCLR, 32'h0);
      chk(rd, 32'h1 << b);
      apb(1'b1, OFF_INTENCLR, 32'h1 << b);
      stat_raw[b] <= 1'b0;
      repeat (3) @(posedge pclk);
      chk(32'(irq), 32'h0);
      apb(1'b0, OFF_INTFLAG, 32'h0);
      chk(rd, 32'h1 << b);
      apb(1'b1, OFF_INTFLAG, 32'h1 << b);
      apb(1'b0, OFF_INTFLAG, 32'h0);
      chk(rd, 32'h0);
    end
    // brown-out flag wakes only in standby
    sleep_mode <= MODE_STANDBY;
    stat_raw[ST_BOD_IO] <= 1'b1;
    apb(1'b1, OFF_INTENSET, 32'h1 << ST_BOD_IO);
    repeat (10) @(posedge pclk);
    chk({30'h0, wake, irq}, 32'h3);
    sleep_mode <= MODE_ACTIVE;
    repeat (2) @(posedge pclk);
    chk(32'(wake), 32'h0);
    test_done();
  end
endmodule : osc_ctrl_top_bench
